/* File: dv/meas_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module meas_ctrl_props (
    // Clock, reset and host port
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_ff,
    // Mode events and engine controls
    input wire logic        sleep_entry,
    input wire logic        cyclic_entry,
    input wire logic        cell16_primary_enable_ff,
    input wire logic        cell16_secondary_enable_ff,
    input wire logic        cell17_primary_enable_ff,
    input wire logic        cell17_secondary_enable_ff,
    input wire logic        acquisition_run_ff,
    input wire logic        result_clear_ff,
    input wire logic        cyclic_meas_start_ff,
    input wire logic        balance_pause_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [15:0] hold_cnt;
    wire         up_wr  = reg_wr && reg_addr == 16'h1409;
    wire         gen_wr = reg_wr && reg_addr == 16'h1800 && !sleep_entry;
    // Length of the current pause in clock cycles
    always_ff @(posedge sys_clk or posedge rst)
        if (rst)
            hold_cnt <= 16'h0000;
        else if (balance_pause_ff)
            hold_cnt <= hold_cnt + 16'h0001;
        else
            hold_cnt <= 16'h0000;
    chk_upper_enables: assert property (up_wr |=>
        {cell17_primary_enable_ff, cell16_primary_enable_ff,
         cell17_secondary_enable_ff, cell16_secondary_enable_ff}
        == {2{$past(reg_wdata[1:0])}}) else $error("cell enable mismatch");
    chk_upper_readzero: assert property (
        reg_rd && reg_addr == 16'h1409 |=> reg_rdata_ff == 16'h0000)
        else $error("upper enable read not zero");
    chk_zero_clears: assert property (
        gen_wr && !reg_wdata[0] |=> result_clear_ff && !acquisition_run_ff)
        else $error("no result clear");
    chk_acq_set: assert property (gen_wr && reg_wdata[0] |=>
        acquisition_run_ff) else $error("acquisition not running");
    chk_sleep_clears: assert property (sleep_entry |=>
        !acquisition_run_ff) else $error("sleep left acquisition on");
    chk_pause_ends: assert property ($fell(balance_pause_ff) |->
        cyclic_meas_start_ff) else $error("no start after pause");
    chk_pause_span: assert property ($fell(balance_pause_ff) |->
        hold_cnt >= 16'h07CF) else $error("pause shorter than a step");
    chk_no_self_pause: assert property (
        !cyclic_entry && !balance_pause_ff |=> !balance_pause_ff)
        else $error("pause without cyclic entry");
    cov_start: cover property (cyclic_meas_start_ff);
    cov_clear: cover property (result_clear_ff);
    cov_pause: cover property ($fell(balance_pause_ff));
endmodule
bind meas_enable_bal_pause_ctrl meas_ctrl_props i_props (.sys_clk, .rst,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff, .sleep_entry,
    .cyclic_entry, .cell16_primary_enable_ff, .cell16_secondary_enable_ff,
    .cell17_primary_enable_ff, .cell17_secondary_enable_ff,
    .acquisition_run_ff, .result_clear_ff, .cyclic_meas_start_ff,
    .balance_pause_ff);
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk, rst, reg_wr, reg_rd, sleep_entry, cyclic_entry;
    logic [15:0] reg_addr, reg_wdata, reg_rdata_ff;
    logic        c16p, c16s, c17p, c17s, acq, clr, start, pause;
    int          n_mismatch, cmp_count, n;
    meas_enable_bal_pause_ctrl i_meas_enable_bal_pause_ctrl (.sys_clk, .rst,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_ff, .sleep_entry,
        .cyclic_entry, .cell16_primary_enable_ff(c16p),
        .cell16_secondary_enable_ff(c16s), .cell17_primary_enable_ff(c17p),
        .cell17_secondary_enable_ff(c17s), .acquisition_run_ff(acq),
        .result_clear_ff(clr), .cyclic_meas_start_ff(start),
        .balance_pause_ff(pause));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input logic [3:0] ctl, input logic [15:0] a, d);
        @(posedge sys_clk);
        #1;
        {reg_wr, reg_rd, sleep_entry, cyclic_entry} = ctl;
        reg_addr = a;
        reg_wdata = d;
    endtask
    task automatic wr(input logic [15:0] a, d);
        step(4'h8, a, d);
        step(4'h0, 16'h0000, 16'h0000);
    endtask
    task automatic rd(input logic [15:0] a, exp);
        step(4'h4, a, 16'h0000);
        step(4'h0, 16'h0000, 16'h0000);
        chk(reg_rdata_ff, exp);
    endtask
    task automatic report_and_stop;
        $display("TB: checks=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_upper;
        wr(16'h1409, 16'hFFFF);
        chk({12'h000, c17p, c17s, c16p, c16s}, 16'h000F);
        rd(16'h1409, 16'h0000);
        wr(16'h1409, 16'h0002);
        chk({12'h000, c17p, c17s, c16p, c16s}, 16'h000C);
        wr(16'h1409, 16'h0001);
        wr(16'h1801, 16'hFFFF);
        chk({12'h000, c17p, c17s, c16p, c16s}, 16'h0003);
    endtask
    task automatic t_acq;
        wr(16'h1800, 16'hFFFD);
        chk({13'h0000, acq, clr, pause}, 16'h0004);
        rd(16'h1800, 16'hFFFD);
        wr(16'h1800, 16'h0000);
        chk({14'h0000, acq, clr}, 16'h0001);
        wr(16'h1800, 16'h0001);
        step(4'h2, 16'h0000, 16'h0000);
        step(4'h0, 16'h0000, 16'h0000);
        chk({15'h0000, acq}, 16'h0000);
        rd(16'h1800, 16'h0000);
    endtask
    task automatic t_cyclic(input logic [15:0] cfg, input int lo, hi);
        wr(16'h1800, cfg);
        step(4'h1, 16'h0000, 16'h0000);
        step(4'h0, 16'h0000, 16'h0000);
        n = 0;
        while (!start && n < 9000) begin
            // Shorter length written mid-pause must not cut the pause short
            if (n == 1)
                step(4'h8, 16'h1800, 16'h0006);
            else
                step(4'h0, 16'h0000, 16'h0000);
            n++;
        end
        if (n == 9000) begin
            n_mismatch++;
            report_and_stop();
        end
        chk({15'h0000, n >= lo && n <= hi}, 16'h0001);
        chk({15'h0000, pause}, 16'h0000);
    endtask
    initial begin
        {rst, reg_wr, reg_rd, sleep_entry, cyclic_entry} = 5'h10;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        chk({8'h00, c16p, c16s, c17p, c17s, acq, clr, start, pause}, 0);
        rd(16'h1800, 16'h0000);
        t_upper();
        t_acq();
        t_cyclic(16'h0002, 0, 0);
        t_cyclic(16'h000A, 3990, 4005);
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: inc/meas_ctrl_regs.vh */
`ifndef MEAS_CTRL_REGS_VH
`define MEAS_CTRL_REGS_VH

// Register offsets (word addresses on the host register port)
`define CELL_MEAS_ENABLE_UPPER_ADDR   16'h1409
`define GENERAL_MEAS_CONTROL_ADDR     16'h1800

// Upper cell-enable fields
`define CELL16_BOTH_CHAIN_ENABLE_BIT  0
`define CELL17_BOTH_CHAIN_ENABLE_BIT  1
`define CELL_MEAS_ENABLE_UPPER_RESET  16'h0000

// General measurement control fields
`define ACQUISITION_ENABLE_BIT        0
`define CYCLIC_AUTO_PAUSE_ENABLE_BIT  1
`define BALANCE_PAUSE_LENGTH_LSB      2
`define BALANCE_PAUSE_LENGTH_MSB      15
`define GENERAL_MEAS_CONTROL_RESET    16'h0000

// Timing: one pause step in ns, clock period in ns
`define PAUSE_ONE_STEP_NS             10000
`define SYS_CLK_PERIOD_NS             5
`define PAUSE_ONE_STEP_CYCLES         (`PAUSE_ONE_STEP_NS / `SYS_CLK_PERIOD_NS)

`endif

/* File: logic/meas_enable_bal_pause_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "meas_ctrl_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - A one written to bit 1 of the upper enable register enables cell 17 in both chains.
// - A one written to bit 0 of the upper enable register enables cell 16 in both chains.
// - Bits 15 to 2 of the upper enable register are reserved, hold zero and ignore writes.
// - The 14-bit pause length in bits 15 to 2 sets the balancing pause in 10 us steps.
// - A pause length of zero gives no pause and all ones gives 163830 us.
// - A new pause length does not change a pause already running.
// - With auto pause enabled, Cyclic entry waits for the pause counter before measuring.
// - Clearing the acquisition enable clears and invalidates all results and ready flags.
// - Sleep entry clears the acquisition enable.
// - Cyclic measurements run whatever the acquisition enable says.
// - Setting the acquisition enable does not by itself stop balancing.
// - The acquisition enable runs acquisition when one and resets to zero.
module meas_enable_bal_pause_ctrl #(
    parameter PAUSE_W = 14
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Host register port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata_ff,
    // Mode events
    input  wire        sleep_entry,
    input  wire        cyclic_entry,
    // Measurement engine
    output reg         cell16_primary_enable_ff,
    output reg         cell16_secondary_enable_ff,
    output reg         cell17_primary_enable_ff,
    output reg         cell17_secondary_enable_ff,
    output reg         acquisition_run_ff,
    output reg         result_clear_ff,
    output reg         cyclic_meas_start_ff,
    output reg         balance_pause_ff
);

    localparam ST_IDLE  = 2'b00;
    localparam ST_PAUSE = 2'b01;
    localparam ST_START = 2'b10;
    localparam TICK_W   = 11;
    // Reset images of the two registers
    localparam [15:0] UPPER_RST   = `CELL_MEAS_ENABLE_UPPER_RESET;
    localparam [15:0] GENERAL_RST = `GENERAL_MEAS_CONTROL_RESET;

    reg  [PAUSE_W-1:0] balance_pause_length_ff;
    reg                cyclic_auto_pause_enable_ff;
    reg                acquisition_enable_ff;
    reg  [PAUSE_W-1:0] pause_count_ff;
    reg  [1:0]         state_ff;
    reg  [1:0]         nxt_state;
    reg  [PAUSE_W-1:0] nxt_pause_count;
    reg                nxt_acq_en;
    wire               wr_upper;
    wire               wr_general;
    wire               step_tick;
    wire [15:0]        general_rd;
    wire               clear_on_write;
    wire               clear_on_sleep;
    wire               pause_last;

    assign wr_upper   = reg_wr && (reg_addr == `CELL_MEAS_ENABLE_UPPER_ADDR);
    assign wr_general = reg_wr && (reg_addr == `GENERAL_MEAS_CONTROL_ADDR);
    assign general_rd = {balance_pause_length_ff,
                         cyclic_auto_pause_enable_ff,
                         acquisition_enable_ff};
    // Sleep only pulses the clear when it really drops the enable
    assign clear_on_write = wr_general && !reg_wdata[`ACQUISITION_ENABLE_BIT];
    assign clear_on_sleep = sleep_entry && acquisition_enable_ff;
    assign pause_last     = (pause_count_ff == {{(PAUSE_W-1){1'b0}}, 1'b1});

    ////////////////////////////////////////////////////////////////////////////
    // 10 us step tick, restarted with each pause so the first step is whole

    pause_step_counter #(
        .CYCLES (`PAUSE_ONE_STEP_CYCLES),
        .WIDTH  (TICK_W)
    ) u_step (
        .sys_clk (sys_clk),
        .rst     (rst),
        .restart (state_ff != ST_PAUSE),
        .tick_ff (step_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Upper cell-enable register; write only, bits 15:2 are not stored

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cell16_primary_enable_ff   <=
                UPPER_RST[`CELL16_BOTH_CHAIN_ENABLE_BIT];
            cell16_secondary_enable_ff <=
                UPPER_RST[`CELL16_BOTH_CHAIN_ENABLE_BIT];
            cell17_primary_enable_ff   <=
                UPPER_RST[`CELL17_BOTH_CHAIN_ENABLE_BIT];
            cell17_secondary_enable_ff <=
                UPPER_RST[`CELL17_BOTH_CHAIN_ENABLE_BIT];
        end else if (wr_upper) begin
            cell17_primary_enable_ff   <=
                reg_wdata[`CELL17_BOTH_CHAIN_ENABLE_BIT];
            cell17_secondary_enable_ff <=
                reg_wdata[`CELL17_BOTH_CHAIN_ENABLE_BIT];
            cell16_primary_enable_ff   <=
                reg_wdata[`CELL16_BOTH_CHAIN_ENABLE_BIT];
            cell16_secondary_enable_ff <=
                reg_wdata[`CELL16_BOTH_CHAIN_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General measurement control register

    always @* begin
        nxt_acq_en = acquisition_enable_ff;
        if (wr_general)
            nxt_acq_en = reg_wdata[`ACQUISITION_ENABLE_BIT];
        if (sleep_entry)
            nxt_acq_en = 1'b0;
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            balance_pause_length_ff     <= GENERAL_RST[
                `BALANCE_PAUSE_LENGTH_MSB:`BALANCE_PAUSE_LENGTH_LSB];
            cyclic_auto_pause_enable_ff <=
                GENERAL_RST[`CYCLIC_AUTO_PAUSE_ENABLE_BIT];
            acquisition_enable_ff       <=
                GENERAL_RST[`ACQUISITION_ENABLE_BIT];
            acquisition_run_ff          <= 1'b0;
            result_clear_ff             <= 1'b0;
        end else begin
            if (wr_general) begin
                balance_pause_length_ff     <= reg_wdata[
                    `BALANCE_PAUSE_LENGTH_MSB:`BALANCE_PAUSE_LENGTH_LSB];
                cyclic_auto_pause_enable_ff <=
                    reg_wdata[`CYCLIC_AUTO_PAUSE_ENABLE_BIT];
            end
            acquisition_enable_ff <= nxt_acq_en;
            acquisition_run_ff    <= nxt_acq_en;
            // One-cycle clear pulse on any write of zero or sleep clear
            result_clear_ff <= clear_on_write || clear_on_sleep;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cyclic entry sequencing with auto balancing pause

    always @* begin
        nxt_state       = state_ff;
        nxt_pause_count = pause_count_ff;
        case (state_ff)
            ST_IDLE: begin
                // Cyclic start does not look at the acquisition enable
                if (cyclic_entry) begin
                    if (cyclic_auto_pause_enable_ff &&
                        (balance_pause_length_ff != {PAUSE_W{1'b0}})) begin
                        nxt_pause_count = balance_pause_length_ff;
                        nxt_state       = ST_PAUSE;
                    end else begin
                        nxt_state = ST_START;
                    end
                end
            end
            ST_PAUSE: begin
                // Counter only reloads on entry, so field edits wait
                if (step_tick) begin
                    nxt_pause_count = pause_count_ff -
                                      {{(PAUSE_W-1){1'b0}}, 1'b1};
                    if (pause_last)
                        nxt_state = ST_START;
                end
            end
            ST_START: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff             <= ST_IDLE;
            pause_count_ff       <= {PAUSE_W{1'b0}};
            cyclic_meas_start_ff <= 1'b0;
            balance_pause_ff     <= 1'b0;
        end else begin
            state_ff             <= nxt_state;
            pause_count_ff       <= nxt_pause_count;
            cyclic_meas_start_ff <= (nxt_state == ST_START);
            // Only the auto pause halts balancing here, never acquisition
            balance_pause_ff     <= (nxt_state == ST_PAUSE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port; the upper enable register is write only and reads zero

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `GENERAL_MEAS_CONTROL_ADDR: begin
                    reg_rdata_ff <= general_rd;
                end
                `CELL_MEAS_ENABLE_UPPER_ADDR: begin
                    // Write-only register, reserved bits never stored
                    reg_rdata_ff <= 16'h0000;
                end
                default: begin
                    reg_rdata_ff <= 16'h0000;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: logic/pause_step_counter.v */
`timescale 1ns/1ps
`default_nettype none

module pause_step_counter #(
    parameter CYCLES = 2000,
    parameter WIDTH  = 11
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    // Control
    input  wire             restart,
    // Tick
    output reg              tick_ff
);

    reg  [WIDTH-1:0] count_ff;
    wire             wrap;

    assign wrap = (count_ff == CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1});

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_ff <= {WIDTH{1'b0}};
            tick_ff  <= 1'b0;
        end else if (restart) begin
            count_ff <= {WIDTH{1'b0}};
            tick_ff  <= 1'b0;
        end else begin
            count_ff <= wrap ? {WIDTH{1'b0}}
                             : count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
            tick_ff  <= wrap;
        end
    end

endmodule

`default_nettype wire
